// [logic/rri_consts.svh]
// Offsets, reset values and field positions of the reset-value initializer
`ifndef RRI_CONSTS_SVH
`define RRI_CONSTS_SVH

// Register offsets on the register port
`define RRI_OFS_STACK_TOP_UPPER      5'h00
`define RRI_OFS_STACK_TOP_HIGH       5'h01
`define RRI_OFS_STACK_TOP_LOW        5'h02
`define RRI_OFS_RETURN_STACK_POINTER 5'h03
`define RRI_OFS_INTERRUPT_CONTROL    5'h04
`define RRI_OFS_PERIPHERAL_REQUEST   5'h05
`define RRI_OFS_TIMER2_PERIOD        5'h06
`define RRI_OFS_NVM_UNLOCK_SEQUENCE  5'h07
`define RRI_OFS_TIMER1_CONTROL       5'h08
`define RRI_OFS_RESET_CAUSE_STATUS   5'h09
`define RRI_OFS_OSCILLATOR_CONTROL   5'h0a
`define RRI_OFS_PORT_A_INPUT         5'h0b
`define RRI_OFS_PORT_A_OUTPUT_LATCH  5'h0c
`define RRI_OFS_PORT_A_DIRECTION     5'h0d
`define RRI_OFS_PORT_E_INPUT         5'h0e
`define RRI_OFS_PORT_E_OUTPUT_LATCH  5'h0f
`define RRI_OFS_SERIAL_TX_STATUS     5'h10
`define RRI_OFS_BAUD_RATE_CONTROL    5'h11
`define RRI_OFS_PORT_A_DIGITAL       5'h12

// Reset values and implemented-bit masks
`define RRI_RST_ALL_ZERO             8'h00
`define RRI_RST_ALL_ONES             8'hff
`define RRI_RST_TIMER1_MID_CLR       8'hbf
`define RRI_RST_SERIAL_TX            8'h02
`define RRI_MSK_SERIAL_TX            8'hf7
`define RRI_RST_BAUD_RATE            8'h50
`define RRI_MSK_BAUD_RATE            8'h5b
`define RRI_RST_PORT_A_DIGITAL       8'hd0
`define RRI_MSK_PORT_A_OSC_PINS      8'h3f
`define RRI_MSK_RESET_CAUSE          8'h9f
`define RRI_MSK_STACK_POINTER        8'hdf
`define RRI_MSK_STACK_TOP_UPPER      8'h1f
`define RRI_MSK_OSC_CONTROL_RW       8'hf7
`define RRI_RST_RESET_CAUSE          8'h1c
`define RRI_MSK_RESET_CAUSE_SW       8'h93
`define RRI_MSK_RESET_CAUSE_HW       8'h0c

// Field positions
`define RRI_BIT_HIGH_PRIORITY_GLOBAL_ENABLE                 7
`define RRI_BIT_LOW_PRIORITY_GLOBAL_ENABLE                 6
`define RRI_BIT_T1_MID_CLEAR         6
`define RRI_BIT_OSC_STATUS           3
`define RRI_BIT_IPEN                 7
`define RRI_BIT_RI                   4
`define RRI_BIT_TO                   3
`define RRI_BIT_PD                   2
`define RRI_BIT_POR                  1
`define RRI_BIT_BOR                  0
`define RRI_BIT_STK_FULL             7
`define RRI_BIT_STK_UNDER            6
`define RRI_BIT_PORT_E3              3

// Program counter values
`define RRI_PC_RESET                 21'h000000
`define RRI_PC_VEC_HIGH              21'h000008
`define RRI_PC_VEC_LOW               21'h000018
`define RRI_PC_STEP                  21'h000002

`endif

// [logic/rri_pkg.sv]
// Types shared by the reset-value initializer
package rri_pkg;

    // Initialization set chosen in a cycle
    typedef enum logic [1:0] {
        RRI_CLASS_NONE = 2'b00,
        RRI_CLASS_POR  = 2'b01,
        RRI_CLASS_MID  = 2'b10,
        RRI_CLASS_WAKE = 2'b11
    } rri_class_e;

    // Power state in which a pin reset lands
    typedef enum logic [1:0] {
        RRI_PM_FULL       = 2'b00,
        RRI_PM_RUN        = 2'b01,
        RRI_PM_IDLE_SLEEP = 2'b10
    } rri_power_e;

    // Reset and wake-up sources, one-cycle pulses on ref_clk
    typedef struct packed {
        logic power_on;
        logic brown_out;
        logic pin_reset;
        logic watchdog_reset;
        logic reset_instr;
        logic stack_full;
        logic stack_underflow;
        logic wake_watchdog;
        logic wake_interrupt;
    } rri_events_s;

    // Register port request
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rri_bus_req_s;

endpackage

// [logic/rri_register_reset_initializer.sv]
// Special function register file with reset-class dependent initialization
// Summary of operation
// - Three value sets: power-on, other resets, wake.
// - Retained bits keep value; unknown bits left alone.
// - Unimplemented bits always read as zero.
// - Interrupt or watchdog wake sets cause flags.
// - Interrupt wake with enable loads vector address.
// - Vectored interrupt wake copies PC into stack top.
// - Vectored interrupt wake advances return stack pointer.
// - Port A bits 7:6 need freeing oscillator mode.
// - Port E bit 3 needs reset pin disabled.
// - Small package: port E holds only bit 3.
// - Timer-2 period resets to all ones always.
// - Unlock sequence register always reads zero.
// - Timer-1 control: full clear, bit 6 on other resets.
// - Reset cause status follows the reset cause.
// - Oscillator control zero except conditional bit 3.
// - Port A input bits 5,3:0 read zero until set in the digital-enable mask.
// - Transmit status resets 0x02, bit 3 absent.
// - Baud control resets 0x50, bits 7,5,2 absent.
// - Power-on clears POR/BOR, sets RI/TO/PD.
`timescale 1ns/1ps
`default_nettype none
`include "rri_consts.svh"

module rri_register_reset_initializer
    import rri_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Reset and wake-up sources
    input  wire rri_events_s events,
    input  wire rri_power_e  power_mode,
    input  wire logic        wake_high_priority,
    input  wire logic [7:0]  wake_intcon_flags,
    input  wire logic [7:0]  wake_pir_flags,
    // Core state
    input  wire logic [20:0] pc_current,
    // Configuration levels
    input  wire logic        osc_frees_port_a_pins,
    input  wire logic        external_reset_pin_enabled,
    input  wire logic        osc_status_level,
    // Pins
    input  wire logic [7:0]  port_a_pins,
    input  wire logic [3:0]  port_e_pins,
    // Register port
    input  wire rri_bus_req_s bus_req,
    output logic [7:0]       bus_rdata,
    // Program counter load
    output logic             pc_load_valid,
    output logic [20:0]      pc_load_value
);

    rri_class_e  cls;
    logic        wake_vector;
    logic        wr;
    logic [7:0]  wd;
    logic [4:0]  wa;
    logic [7:0]  pa_s1_q, pa_s2_q, pa_s3_q, pa_filt_q;
    logic [3:0]  pe_s1_q, pe_s2_q, pe_s3_q, pe_filt_q;
    logic [7:0]  tos_u_q, tos_h_q, tos_l_q, return_stack_pointer_q;
    logic [7:0]  intcon_q, pir_q, t2_period_q, t1_control_q;
    logic [7:0]  reset_cause_status_q, osc_control_q, pa_latch_q, pa_dir_q, pa_digital_q;
    logic [3:0]  pe_latch_q;
    logic [7:0]  tx_status_q, baud_q;
    logic [7:0]  pa_gate, pa_read, pe_read;
    logic [3:0]  pe_gate;
    logic [7:0]  rdata_d;

    assign wr = bus_req.wr;
    assign wd = bus_req.wdata;
    assign wa = bus_req.addr;

    // Power-on and brown-out outrank all else; srst counts as power-on
    always_comb begin
        if (srst || events.power_on || events.brown_out) begin
            cls = RRI_CLASS_POR;
        end else if (events.pin_reset || events.watchdog_reset || events.reset_instr
                     || events.stack_full || events.stack_underflow) begin
            cls = RRI_CLASS_MID;
        end else if (events.wake_watchdog || events.wake_interrupt) begin
            cls = RRI_CLASS_WAKE;
        end else begin
            cls = RRI_CLASS_NONE;
        end
    end

    // Vectoring only for interrupt wake with a global enable set
    assign wake_vector = (cls == RRI_CLASS_WAKE) && events.wake_interrupt
                         && (intcon_q[`RRI_BIT_HIGH_PRIORITY_GLOBAL_ENABLE] || intcon_q[`RRI_BIT_LOW_PRIORITY_GLOBAL_ENABLE]);

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        pa_s1_q   <= port_a_pins;
        pa_s2_q   <= pa_s1_q;
        pa_s3_q   <= pa_s2_q;
        pa_filt_q <= (~(pa_s2_q ^ pa_s3_q) & pa_s3_q) | ((pa_s2_q ^ pa_s3_q) & pa_filt_q);
        pe_s1_q   <= port_e_pins;
        pe_s2_q   <= pe_s1_q;
        pe_s3_q   <= pe_s2_q;
        pe_filt_q <= (~(pe_s2_q ^ pe_s3_q) & pe_s3_q) | ((pe_s2_q ^ pe_s3_q) & pe_filt_q);
    end

    // Stack top: cleared on resets, loaded with the PC on vectored wake
    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR || cls == RRI_CLASS_MID) begin
            tos_u_q <= `RRI_RST_ALL_ZERO;
            tos_h_q <= `RRI_RST_ALL_ZERO;
            tos_l_q <= `RRI_RST_ALL_ZERO;
        end else if (wake_vector) begin
            tos_u_q <= {3'h0, pc_current[20:16]};
            tos_h_q <= pc_current[15:8];
            tos_l_q <= pc_current[7:0];
        end else if (wr) begin
            if (wa == `RRI_OFS_STACK_TOP_UPPER) tos_u_q <= wd & `RRI_MSK_STACK_TOP_UPPER;
            if (wa == `RRI_OFS_STACK_TOP_HIGH)  tos_h_q <= wd;
            if (wa == `RRI_OFS_STACK_TOP_LOW)   tos_l_q <= wd;
        end
    end

    // Stack pointer: overflow flags kept across non-power resets
    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR) begin
            return_stack_pointer_q <= `RRI_RST_ALL_ZERO;
        end else if (cls == RRI_CLASS_MID) begin
            return_stack_pointer_q[4:0] <= 5'h00;
            if (events.stack_full)      return_stack_pointer_q[`RRI_BIT_STK_FULL]  <= 1'b1;
            if (events.stack_underflow) return_stack_pointer_q[`RRI_BIT_STK_UNDER] <= 1'b1;
        end else if (wake_vector) begin
            return_stack_pointer_q[4:0] <= return_stack_pointer_q[4:0] + 5'h01;
        end else if (wr && wa == `RRI_OFS_RETURN_STACK_POINTER) begin
            return_stack_pointer_q <= wd & `RRI_MSK_STACK_POINTER;
        end
    end

    // Interrupt control and request flags; wake flags win over a write
    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR) begin
            intcon_q <= `RRI_RST_ALL_ZERO;
            pir_q    <= `RRI_RST_ALL_ZERO;
        end else if (cls == RRI_CLASS_MID) begin
            intcon_q <= {7'h00, intcon_q[0]};
            pir_q    <= `RRI_RST_ALL_ZERO;
        end else begin
            if (cls == RRI_CLASS_WAKE) begin
                intcon_q <= ((wr && wa == `RRI_OFS_INTERRUPT_CONTROL) ? wd : intcon_q)
                            | wake_intcon_flags;
                pir_q    <= ((wr && wa == `RRI_OFS_PERIPHERAL_REQUEST) ? wd : pir_q)
                            | wake_pir_flags;
            end else if (wr) begin
                if (wa == `RRI_OFS_INTERRUPT_CONTROL)  intcon_q <= wd;
                if (wa == `RRI_OFS_PERIPHERAL_REQUEST) pir_q    <= wd;
            end
        end
    end

    // Timer-2 period: every reset and wake restores all ones
    always_ff @(posedge ref_clk) begin
        if (cls != RRI_CLASS_NONE) begin
            t2_period_q <= `RRI_RST_ALL_ONES;
        end else if (wr && wa == `RRI_OFS_TIMER2_PERIOD) begin
            t2_period_q <= wd;
        end
    end

    // Timer-1 control: full clear on power-on, one bit on other resets
    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR) begin
            t1_control_q <= `RRI_RST_ALL_ZERO;
        end else if (cls == RRI_CLASS_MID) begin
            t1_control_q <= t1_control_q & `RRI_RST_TIMER1_MID_CLR;
        end else if (wr && wa == `RRI_OFS_TIMER1_CONTROL) begin
            t1_control_q <= wd;
        end
    end

    // Reset cause status; hardware events win over software writes
    always_ff @(posedge ref_clk) begin
        if (srst || events.power_on) begin
            reset_cause_status_q <= `RRI_RST_RESET_CAUSE;
        end else if (events.brown_out) begin
            reset_cause_status_q[`RRI_BIT_IPEN] <= 1'b0;
            reset_cause_status_q[`RRI_BIT_RI]   <= 1'b1;
            reset_cause_status_q[`RRI_BIT_TO]   <= 1'b1;
            reset_cause_status_q[`RRI_BIT_PD]   <= 1'b1;
            reset_cause_status_q[`RRI_BIT_BOR]  <= 1'b0;
        end else if (cls == RRI_CLASS_MID) begin
            reset_cause_status_q[`RRI_BIT_IPEN] <= 1'b0;
            if (events.reset_instr) reset_cause_status_q[`RRI_BIT_RI] <= 1'b0;
            if (events.watchdog_reset) reset_cause_status_q[`RRI_BIT_TO] <= 1'b0;
            if (events.pin_reset && power_mode != RRI_PM_FULL) reset_cause_status_q[`RRI_BIT_TO] <= 1'b1;
            if (events.pin_reset && power_mode == RRI_PM_IDLE_SLEEP) begin
                reset_cause_status_q[`RRI_BIT_PD] <= 1'b0;
            end
        end else if (cls == RRI_CLASS_WAKE) begin
            reset_cause_status_q[`RRI_BIT_PD] <= 1'b0;
            if (events.wake_watchdog) reset_cause_status_q[`RRI_BIT_TO] <= 1'b0;
        end else if (wr && wa == `RRI_OFS_RESET_CAUSE_STATUS) begin
            // Time-out and power-down bits are read-only
            reset_cause_status_q <= (wd & `RRI_MSK_RESET_CAUSE_SW) | (reset_cause_status_q & `RRI_MSK_RESET_CAUSE_HW);
        end
    end

    // Oscillator control; status bit follows the oscillator condition
    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR || cls == RRI_CLASS_MID) begin
            osc_control_q <= `RRI_RST_ALL_ZERO;
        end else if (wr && wa == `RRI_OFS_OSCILLATOR_CONTROL) begin
            osc_control_q <= wd & `RRI_MSK_OSC_CONTROL_RW;
        end
    end

    // Port A latch, direction and digital-enable mask
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pa_latch_q <= `RRI_RST_ALL_ZERO; // Defined start for simulation only
        end else if (wr && wa == `RRI_OFS_PORT_A_OUTPUT_LATCH) begin
            pa_latch_q <= wd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR || cls == RRI_CLASS_MID) begin
            pa_dir_q     <= `RRI_RST_ALL_ONES;
            pa_digital_q <= `RRI_RST_PORT_A_DIGITAL;
        end else if (wr) begin
            if (wa == `RRI_OFS_PORT_A_DIRECTION) pa_dir_q     <= wd;
            if (wa == `RRI_OFS_PORT_A_DIGITAL)   pa_digital_q <= wd;
        end
    end

    // Port E latch: only gated bits are ever stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pe_latch_q <= 4'h0;
        end else if (wr && wa == `RRI_OFS_PORT_E_OUTPUT_LATCH) begin
            pe_latch_q <= wd[3:0] & pe_gate;
        end
    end

    // Serial transmit status and baud-rate control
    always_ff @(posedge ref_clk) begin
        if (cls == RRI_CLASS_POR || cls == RRI_CLASS_MID) begin
            tx_status_q <= `RRI_RST_SERIAL_TX;
            baud_q      <= `RRI_RST_BAUD_RATE;
        end else if (wr) begin
            if (wa == `RRI_OFS_SERIAL_TX_STATUS)  tx_status_q <= wd & `RRI_MSK_SERIAL_TX;
            if (wa == `RRI_OFS_BAUD_RATE_CONTROL) baud_q      <= wd & `RRI_MSK_BAUD_RATE;
        end
    end

    // Pin gating by oscillator mode, reset-pin use and package size
    assign pa_gate = osc_frees_port_a_pins ? `RRI_RST_ALL_ONES
                                           : `RRI_MSK_PORT_A_OSC_PINS;
    assign pe_gate = {~external_reset_pin_enabled,
                      SMALL_PACKAGE ? 3'h0 : 3'h7};
    assign pa_read = pa_filt_q & pa_digital_q & pa_gate;
    assign pe_read = {4'h0, pe_filt_q & pe_gate};

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        case (wa)
            `RRI_OFS_STACK_TOP_UPPER:      rdata_d = tos_u_q;
            `RRI_OFS_STACK_TOP_HIGH:       rdata_d = tos_h_q;
            `RRI_OFS_STACK_TOP_LOW:        rdata_d = tos_l_q;
            `RRI_OFS_RETURN_STACK_POINTER: rdata_d = return_stack_pointer_q;
            `RRI_OFS_INTERRUPT_CONTROL:    rdata_d = intcon_q;
            `RRI_OFS_PERIPHERAL_REQUEST:   rdata_d = pir_q;
            `RRI_OFS_TIMER2_PERIOD:        rdata_d = t2_period_q;
            `RRI_OFS_NVM_UNLOCK_SEQUENCE:  rdata_d = `RRI_RST_ALL_ZERO;
            `RRI_OFS_TIMER1_CONTROL:       rdata_d = t1_control_q;
            `RRI_OFS_RESET_CAUSE_STATUS:   rdata_d = reset_cause_status_q & `RRI_MSK_RESET_CAUSE;
            `RRI_OFS_OSCILLATOR_CONTROL:   rdata_d = osc_control_q
                                               | {4'h0, osc_status_level, 3'h0};
            `RRI_OFS_PORT_A_INPUT:         rdata_d = pa_read;
            `RRI_OFS_PORT_A_OUTPUT_LATCH:  rdata_d = pa_latch_q & pa_gate;
            `RRI_OFS_PORT_A_DIRECTION:     rdata_d = pa_dir_q & pa_gate;
            `RRI_OFS_PORT_E_INPUT:         rdata_d = pe_read;
            `RRI_OFS_PORT_E_OUTPUT_LATCH:  rdata_d = {4'h0, pe_latch_q & pe_gate};
            `RRI_OFS_SERIAL_TX_STATUS:     rdata_d = tx_status_q;
            `RRI_OFS_BAUD_RATE_CONTROL:    rdata_d = baud_q;
            `RRI_OFS_PORT_A_DIGITAL:       rdata_d = pa_digital_q;
            default:                       rdata_d = `RRI_RST_ALL_ZERO;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_rdata <= `RRI_RST_ALL_ZERO;
        end else begin
            bus_rdata <= bus_req.rd ? rdata_d : `RRI_RST_ALL_ZERO;
        end
    end

    // Program counter load on every reset and wake
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pc_load_valid <= 1'b1;
            pc_load_value <= `RRI_PC_RESET;
        end else begin
            pc_load_valid <= (cls != RRI_CLASS_NONE);
            if (cls == RRI_CLASS_POR || cls == RRI_CLASS_MID) begin
                pc_load_value <= `RRI_PC_RESET;
            end else if (wake_vector) begin
                pc_load_value <= wake_high_priority ? `RRI_PC_VEC_HIGH
                                                    : `RRI_PC_VEC_LOW;
            end else if (cls == RRI_CLASS_WAKE) begin
                pc_load_value <= pc_current + `RRI_PC_STEP;
            end
        end
    end

endmodule
`default_nettype wire

// [verif/rri_register_reset_initializer_props.sv]
// Port-level property checker for the reset-value initializer
`timescale 1ns/1ps
`default_nettype none
module rri_register_reset_initializer_props
    import rri_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset
    input wire logic         ref_clk,
    input wire logic         srst,
    // Stimulus seen at the block
    input wire rri_events_s  events,
    input wire logic         wake_high_priority,
    input wire logic [20:0]  pc_current,
    input wire logic         osc_frees_port_a_pins,
    input wire logic         external_reset_pin_enabled,
    input wire rri_bus_req_s bus_req,
    // Block answers
    input wire logic [7:0]   bus_rdata,
    input wire logic         pc_load_valid,
    input wire logic [20:0]  pc_load_value
);
    // Any true reset class; these outrank both wake-up sources
    logic rst_any;
    assign rst_any = |events[8:2];

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_reset_loads_zero: assert property (rst_any |=> pc_load_valid && pc_load_value == 21'h0)
        else $error("reset did not load the reset address");
    a_no_spurious_load: assert property (
        !rst_any && !events.wake_watchdog && !events.wake_interrupt |=> !pc_load_valid)
        else $error("program counter load without any cause");
    a_wake_high_target: assert property (!rst_any && events.wake_interrupt && wake_high_priority
        |=> pc_load_valid && (pc_load_value == 21'h8 || pc_load_value == $past(pc_current) + 21'h2))
        else $error("high priority wake loaded a wrong address");
    a_wake_dog_step: assert property (!rst_any && events.wake_watchdog && !events.wake_interrupt
        |=> pc_load_valid && pc_load_value == $past(pc_current) + 21'h2)
        else $error("watchdog wake did not step the program counter");
    a_unlock_reads_zero: assert property (bus_req.rd && bus_req.addr == 5'h07 |=> bus_rdata == 8'h00)
        else $error("unlock sequence register read nonzero");
    a_tx_gap_zero: assert property (bus_req.rd && bus_req.addr == 5'h10 |=> bus_rdata[3] == 1'b0)
        else $error("transmit status bit 3 read nonzero");
    a_baud_gaps_zero: assert property (bus_req.rd && bus_req.addr == 5'h11 |=> (bus_rdata & 8'ha4) == 8'h00)
        else $error("baud control absent bits read nonzero");
    a_reset_cause_status_gaps_zero: assert property (bus_req.rd && bus_req.addr == 5'h09 |=> bus_rdata[6:5] == 2'b00)
        else $error("reset cause absent bits read nonzero");
    a_port_a_input_osc_gate: assert property (bus_req.rd && bus_req.addr inside {5'h0b, 5'h0c, 5'h0d}
        && !osc_frees_port_a_pins |=> bus_rdata[7:6] == 2'b00)
        else $error("port A bits 7:6 visible without oscillator release");
    a_port_e_input_pin_gate: assert property (bus_req.rd && bus_req.addr inside {5'h0e, 5'h0f}
        && external_reset_pin_enabled |=> bus_rdata[3] == 1'b0)
        else $error("port E bit 3 visible while reset pin active");
    a_small_pkg_port_e_input: assert property (bus_req.rd && bus_req.addr == 5'h0e && SMALL_PACKAGE
        |=> (bus_rdata & 8'hf7) == 8'h00)
        else $error("small package port E shows extra bits");

    // Main scenarios reached
    c_wake_load: cover property (events.wake_interrupt ##1 pc_load_valid);
    c_clash: cover property (rst_any && events.wake_interrupt);
    c_port_e_input_read: cover property (bus_req.rd && bus_req.addr == 5'h0e && external_reset_pin_enabled);
endmodule

bind rri_register_reset_initializer rri_register_reset_initializer_props #(
    .SMALL_PACKAGE(SMALL_PACKAGE)
) u_props (
    .ref_clk                    (ref_clk),
    .srst                       (srst),
    .events                     (events),
    .wake_high_priority         (wake_high_priority),
    .pc_current                 (pc_current),
    .osc_frees_port_a_pins      (osc_frees_port_a_pins),
    .external_reset_pin_enabled (external_reset_pin_enabled),
    .bus_req                    (bus_req),
    .bus_rdata                  (bus_rdata),
    .pc_load_valid              (pc_load_valid),
    .pc_load_value              (pc_load_value)
);
`default_nettype wire

// [verif/rri_register_reset_initializer_bench.sv]
// Self-checking bench for the reset-value initializer
`timescale 1ns/1ps
`default_nettype none
module rri_register_reset_initializer_bench;
    import rri_pkg::*;
    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    rri_events_s  events = '0;
    rri_power_e   power_mode = RRI_PM_FULL;
    logic         wake_high_priority = 1'b0;
    logic [20:0]  pc_current = 21'h0;
    logic         osc_frees = 1'b1;
    logic         ext_pin_en = 1'b0;
    logic         osc_status = 1'b1;
    rri_bus_req_s bus_req = '0;
    logic [7:0]   bus_rdata;
    logic         pc_load_valid;
    logic [20:0]  pc_load_value;
    int           err_total = 0;
    int           tests_run = 0;
    // Registers that read zero after power-up, plus one unmapped place
    logic [4:0]   zl [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h13};

    // Small package build so the port E narrowing is exercised
    rri_register_reset_initializer #(.SMALL_PACKAGE(1'b1)) dut (
        .ref_clk                    (ref_clk),
        .srst                       (srst),
        .events                     (events),
        .power_mode                 (power_mode),
        .wake_high_priority         (wake_high_priority),
        .wake_intcon_flags          (8'h04),
        .wake_pir_flags             (8'h01),
        .pc_current                 (pc_current),
        .osc_frees_port_a_pins      (osc_frees),
        .external_reset_pin_enabled (ext_pin_en),
        .osc_status_level           (osc_status),
        .port_a_pins                (8'hff),
        .port_e_pins                (4'hf),
        .bus_req                    (bus_req),
        .bus_rdata                  (bus_rdata),
        .pc_load_valid              (pc_load_valid),
        .pc_load_value              (pc_load_value)
    );

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle write strobe; the gap cycle keeps strobes from merging
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 chk($sformatf("register %h", a), {13'h0, bus_rdata}, {13'h0, e});
    endtask

    // One-cycle event pulse, then the load pulse and its target
    task automatic ev(input logic [8:0] e, input logic [20:0] pcx);
        @(posedge ref_clk);
        events <= e;
        @(posedge ref_clk);
        events <= '0;
        #1 chk("pc_load_valid", {20'h0, pc_load_valid}, 21'h1);
        chk("pc_load_value", pc_load_value, pcx);
        @(posedge ref_clk);
        #1 chk("pc_load_valid low", {20'h0, pc_load_valid}, 21'h0);
    endtask

    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: power-up values, gating, each reset class, wake-up
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (zl[i]) rchk(zl[i], 8'h00);
        rchk(5'h09, 8'h1c);
        rchk(5'h06, 8'hff);
        rchk(5'h0a, 8'h08);
        rchk(5'h0b, 8'hd0);
        rchk(5'h0d, 8'hff);
        rchk(5'h10, 8'h02);
        rchk(5'h11, 8'h50);
        rchk(5'h0e, 8'h08);
        wr(5'h08, 8'hff);
        wr(5'h06, 8'h12);
        wr(5'h07, 8'h55);
        wr(5'h0a, 8'hff);
        wr(5'h0c, 8'hff);
        wr(5'h04, 8'h80);
        rchk(5'h07, 8'h00);
        rchk(5'h06, 8'h12);
        rchk(5'h0a, 8'hff);
        @(posedge ref_clk);
        osc_status <= 1'b0;
        osc_frees <= 1'b0;
        ext_pin_en <= 1'b1;
        power_mode <= RRI_PM_IDLE_SLEEP;
        rchk(5'h0a, 8'hf7);
        rchk(5'h0c, 8'h3f);
        rchk(5'h0d, 8'h3f);
        rchk(5'h0b, 8'h10);
        rchk(5'h0e, 8'h00);
        ev(9'h040, 21'h0);
        rchk(5'h08, 8'hbf);
        rchk(5'h06, 8'hff);
        rchk(5'h09, 8'h18);
        rchk(5'h04, 8'h00);
        ev(9'h020, 21'h0);
        rchk(5'h09, 8'h10);
        ev(9'h010, 21'h0);
        rchk(5'h09, 8'h00);
        ev(9'h008, 21'h0);
        rchk(5'h03, 8'h80);
        ev(9'h004, 21'h0);
        rchk(5'h03, 8'hc0);
        wr(5'h08, 8'hff);
        ev(9'h080, 21'h0);
        rchk(5'h09, 8'h1c);
        rchk(5'h08, 8'h00);
        rchk(5'h03, 8'h00);
        rchk(5'h0a, 8'h00);
        wr(5'h04, 8'h80);
        @(posedge ref_clk);
        pc_current <= 21'h01234;
        wake_high_priority <= 1'b1;
        ev(9'h101, 21'h0);
        rchk(5'h03, 8'h00);
        wr(5'h04, 8'h80);
        ev(9'h001, 21'h00008);
        rchk(5'h00, 8'h00);
        rchk(5'h01, 8'h12);
        rchk(5'h02, 8'h34);
        rchk(5'h03, 8'h01);
        rchk(5'h04, 8'h84);
        rchk(5'h05, 8'h01);
        rchk(5'h09, 8'h18);
        wr(5'h06, 8'h12);
        @(posedge ref_clk);
        pc_current <= 21'h1abcd;
        wake_high_priority <= 1'b0;
        ev(9'h001, 21'h00018);
        rchk(5'h00, 8'h01);
        rchk(5'h01, 8'hab);
        rchk(5'h02, 8'hcd);
        rchk(5'h03, 8'h02);
        rchk(5'h06, 8'hff);
        wr(5'h04, 8'h00);
        ev(9'h001, 21'h1abcf);
        rchk(5'h03, 8'h02);
        ev(9'h002, 21'h1abcf);
        rchk(5'h09, 8'h10);
        rchk(5'h04, 8'h04);
        print_verdict();
    end
endmodule
`default_nettype wire
